// ===== design/gpio_port_pkg.sv
// Purpose: Shared constants for the three-port GPIO block
// Assumes: 24 pins, pin n of port p sits at index 8*p+n
// Notes: Register word index times four gives the AXI byte address
package gpio_port_pkg;
    // Pin count and register word width
    localparam int NUM_PINS = 24;
    localparam int REG_W = 8;
    // Register word indices
    localparam logic [5:0] IDX_PORT0_DATA = 6'h00;
    localparam logic [5:0] IDX_PORT1_DATA = 6'h01;
    localparam logic [5:0] IDX_PORT2_DATA = 6'h02;
    localparam logic [5:0] IDX_FUNC_CTRL = 6'h08;
    localparam logic [5:0] IDX_CFG_BASE = 6'h20;
    localparam logic [5:0] IDX_CFG_LAST = 6'h37;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] FUNC_RESET = 8'h00;
    // Implemented data bits of port 2
    localparam logic [7:0] PORT2_MASK = 8'h03;
    // Per-pin configuration fields
    localparam int CFG_OUT_EN = 0;
    localparam int CFG_PULL_UP = 1;
    localparam int CFG_FLOAT_HIGH = 2;
    localparam int CFG_STRONG_SINK = 3;
    localparam int CFG_TTL = 4;
    localparam int CFG_ACT_LOW = 5;
    localparam int CFG_INT_EN = 6;
    localparam int CFG_LOW_V_DRIVE = 7;
    // Function control fields
    localparam int FN_USB_EN = 0;
    localparam int FN_USB_FORCE = 1;
    localparam int FN_REG_CLAIM = 2;
    localparam int FN_SERIAL_USE = 3;
    localparam int FN_EXT_IRQ_USE = 4;
    localparam int FN_REG_ON = 5;
    // Pins with shared functions
    localparam int PIN_EXT_ONE = 3;
    localparam int PIN_EXT_TWO = 4;
    localparam int PIN_DPLUS = 8;
    localparam int PIN_DMINUS = 9;
    localparam int PIN_REG = 10;
    localparam int PIN_SERIAL_LO = 11;
    localparam int PIN_SERIAL_HI = 14;
    localparam int PIN_SINK_LO = 11;
    localparam int PIN_SINK_HI = 15;
    localparam int PIN_PORT2_LO = 16;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== design/pin_sync.sv
// Purpose: Two-stage synchroniser for pad inputs
// Assumes: One clock, synchronous active-high reset
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys,              // System clock
    input wire logic reset,                // Synchronous reset
    input wire logic [WIDTH-1:0] async_in, // Raw pad levels
    output logic [WIDTH-1:0] sync_out      // Settled levels
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_reg;
            logic stable_reg;
            // Two flops per bit keep metastability off the read path
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end
                else
                begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// ===== design/edge_irq.sv
// Purpose: Edge-triggered interrupt pulses per source
// Assumes: Inputs already synchronised to clk_sys
// Notes: A source fires once per inactive-to-active change
`timescale 1ns/1ns
`default_nettype none
module edge_irq #(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys,             // System clock
    input wire logic reset,               // Synchronous reset
    input wire logic [WIDTH-1:0] level,   // Synchronised level
    input wire logic [WIDTH-1:0] enable,  // Interrupt allowed
    input wire logic [WIDTH-1:0] act_low, // Falling edge select
    output logic [WIDTH-1:0] active,      // Enabled and at trigger level
    output logic [WIDTH-1:0] pulse        // One-cycle interrupt
);
    logic [WIDTH-1:0] prev_reg;

    // Active level is the level reached by the chosen edge
    assign active = enable & (level ^ act_low); // see R3 see R5

    // Remember last active state; toggling act_low can fake an edge
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            prev_reg <= '0;
        else
            prev_reg <= active;
    end

    // Pulse only on the rise of the active state
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            pulse <= '0;
        else
            pulse <= active & ~prev_reg; // see R4
    end
endmodule // edge_irq
`default_nettype wire

// ===== design/gpio_port_block.sv
// Purpose: Three-port GPIO with per-pin config and shared pin functions
// Assumes: AXI4-Lite slave, clk_sys at 125 MHz, synchronous reset
// Notes: Pad drive outputs are registered, one cycle after a write
// What this block does
// R1: Data write sets level on enabled outputs
// R2: Data read returns sampled pin levels
// R3: Interrupt allow bit gates pin interrupt
// R4: Edge triggered; shared interrupt needs all inactive
// R5: Polarity bit selects falling or rising edge
// R6: Driven output can self-generate its interrupt
// R7: Threshold bit selects TTL or CMOS input
// R8: Strong sink only on port1 pins 7..3
// R9: Float-high: one floats, zero drives low
// R10: Float-high clear drives both levels
// R11: Pull-up bit connects pull-up resistor
// R12: Output enable bit turns driver on
// R13: Claimed shared pins leave GPIO control
// R14: Low-voltage drive sources high from regulator
// R15: Software enables regulator separately
// R16: USB mode turns pins into D- D+
// R17: Line override lets data bits set lines
// R18: Port1 pins 6..3 serve serial peripheral
// R19: Port0 pins 4,3 feed external interrupts
// R20: Port2 implements only data bits 1,0
// R21: Software disables interrupt before reconfiguring polarity
// R22: Port1 pin 0 is open-drain only
// R23: Pin inputs pass two-stage synchroniser
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module gpio_port_block #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_sys,                  // System clock
    input wire logic reset,                    // Sync reset
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid,            // Write address valid
    output logic s_axi_awready,                // Write address ready
    input wire logic [31:0] s_axi_wdata,       // Write data
    input wire logic [3:0] s_axi_wstrb,        // Write byte strobes
    input wire logic s_axi_wvalid,             // Write data valid
    output logic s_axi_wready,                 // Write data ready
    output logic [1:0] s_axi_bresp,            // Write response
    output logic s_axi_bvalid,                 // Write response valid
    input wire logic s_axi_bready,             // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid,            // Read address valid
    output logic s_axi_arready,                // Read address ready
    output logic [31:0] s_axi_rdata,           // Read data
    output logic [1:0] s_axi_rresp,            // Read response
    output logic s_axi_rvalid,                 // Read data valid
    input wire logic s_axi_rready,             // Read data ready
    input wire logic [23:0] pin_in,            // Pad input levels
    output logic [23:0] pin_out,               // Pad output levels
    output logic [23:0] pin_oe,                // Pad driver enables
    output logic [23:0] pull_up_en,            // Pull-up connect
    output logic [23:0] ttl_sel,               // TTL threshold
    output logic [23:0] strong_sink,           // High-current sink select
    output logic [23:0] high_from_regulator,   // Rail-sourced high
    output logic [23:0] gpio_irq,              // Per-pin interrupt pulses
    output logic port2_irq,                    // Port 2 interrupt
    output logic ext_irq_one,                  // Ext interrupt one
    output logic ext_irq_two,                  // Ext interrupt two
    output logic regulator_pin_claim,          // Regulator owns its pin
    output logic regulator_on,                 // Regulator enable
    output logic usb_mode,                     // USB owns D+ D-
    input wire logic [1:0] usb_line_out,       // USB drive, bit0 D+
    input wire logic [1:0] usb_line_oe,        // USB core enables
    output logic [1:0] usb_line_in,            // Synced D+ D- levels
    input wire logic [3:0] serial_out,         // Serial unit drive
    input wire logic [3:0] serial_oe,          // Serial unit enables
    output logic serial_data_in_pin            // Synced serial data-in pad
);
    localparam int N = gpio_port_pkg::NUM_PINS;

    logic [23:0] data_reg;
    logic [7:0] cfg_reg [0:N-1];
    logic [7:0] func_reg;
    logic [23:0] pin_sync_lvl;
    logic [23:0] out_next;
    logic [23:0] oe_next;
    logic [23:0] int_en;
    logic [23:0] int_low;
    logic [23:0] pin_active;
    logic [23:0] pin_pulse;
    logic [0:0] group_pulse;
    logic [0:0] group_active;
    logic [0:0] group_level;
    // AXI write side holding state
    logic aw_held_reg;
    logic w_held_reg;
    logic [5:0] wr_idx_reg;
    logic [7:0] wr_data_reg;
    logic wr_lane_reg;
    logic [5:0] rd_idx;
    logic wr_fire;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] rd_byte;

    // Pads settle through two flops before any use
    pin_sync #(
        .WIDTH(N)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(pin_in),
        .sync_out(pin_sync_lvl) // see R23
    );

    // Channel ready while nothing of its kind is held
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit = (wr_idx_reg <= gpio_port_pkg::IDX_PORT2_DATA)
        || (wr_idx_reg == gpio_port_pkg::IDX_FUNC_CTRL)
        || (wr_idx_reg >= gpio_port_pkg::IDX_CFG_BASE
            && wr_idx_reg <= gpio_port_pkg::IDX_CFG_LAST);
    assign rd_idx = s_axi_araddr[7:2];

    // Address and data latch independently, in either order
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            wr_idx_reg <= '0;
            wr_data_reg <= '0;
            wr_lane_reg <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                wr_idx_reg <= s_axi_awaddr[7:2];
            end
            else if (wr_fire)
                aw_held_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wr_data_reg <= s_axi_wdata[7:0];
                wr_lane_reg <= s_axi_wstrb[0];
            end
            else if (wr_fire)
                w_held_reg <= 1'b0;
        end
    end

    // Write response rises on the same edge as the register update
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= gpio_port_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Data registers; only lane 0 carries the 8-bit word
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            data_reg <= {3{gpio_port_pkg::DATA_RESET}};
        else if (wr_fire && wr_lane_reg)
        begin
            case (wr_idx_reg)
                gpio_port_pkg::IDX_PORT0_DATA: data_reg[7:0] <= wr_data_reg; // see R1
                gpio_port_pkg::IDX_PORT1_DATA: data_reg[15:8] <= wr_data_reg; // see R1
                gpio_port_pkg::IDX_PORT2_DATA:
                    data_reg[23:16] <= wr_data_reg & gpio_port_pkg::PORT2_MASK; // see R20
                default: data_reg <= data_reg;
            endcase
        end
    end

    // Function control: USB, override, regulator, serial, ext interrupts
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            func_reg <= gpio_port_pkg::FUNC_RESET;
        else if (wr_fire && wr_lane_reg && wr_idx_reg == gpio_port_pkg::IDX_FUNC_CTRL)
            func_reg <= wr_data_reg;
    end

    // Read data comes from the synchronised pads, not from data_reg
    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = 8'h00;
        if (rd_idx == gpio_port_pkg::IDX_PORT0_DATA)
            rd_byte = pin_sync_lvl[7:0]; // see R2
        else if (rd_idx == gpio_port_pkg::IDX_PORT1_DATA)
            rd_byte = pin_sync_lvl[15:8]; // see R2
        else if (rd_idx == gpio_port_pkg::IDX_PORT2_DATA)
            rd_byte = pin_sync_lvl[23:16] & gpio_port_pkg::PORT2_MASK; // see R2 see R20
        else if (rd_idx == gpio_port_pkg::IDX_FUNC_CTRL)
            rd_byte = func_reg;
        else if (rd_idx >= gpio_port_pkg::IDX_CFG_BASE && rd_idx <= gpio_port_pkg::IDX_CFG_LAST)
            rd_byte = cfg_reg[5'(rd_idx - gpio_port_pkg::IDX_CFG_BASE)];
        else
            rd_hit = 1'b0;
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= gpio_port_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Function bits go straight out
    assign usb_mode = func_reg[gpio_port_pkg::FN_USB_EN]; // see R16
    assign regulator_pin_claim = func_reg[gpio_port_pkg::FN_REG_CLAIM]; // see R13
    assign regulator_on = func_reg[gpio_port_pkg::FN_REG_ON]; // see R15
    assign usb_line_in = pin_sync_lvl[gpio_port_pkg::PIN_DMINUS:gpio_port_pkg::PIN_DPLUS];
    assign serial_data_in_pin = pin_sync_lvl[gpio_port_pkg::PIN_SERIAL_HI]; // see R18

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_pin
            localparam bit IS_DP = (i == gpio_port_pkg::PIN_DPLUS);
            localparam bit IS_USB = IS_DP || (i == gpio_port_pkg::PIN_DMINUS);
            localparam bit IS_REG = (i == gpio_port_pkg::PIN_REG);
            localparam bit IS_SER = (i >= gpio_port_pkg::PIN_SERIAL_LO)
                && (i <= gpio_port_pkg::PIN_SERIAL_HI);
            localparam bit IS_SINK = (i >= gpio_port_pkg::PIN_SINK_LO)
                && (i <= gpio_port_pkg::PIN_SINK_HI);
            localparam bit IS_GONE = (i >= gpio_port_pkg::PIN_PORT2_LO + 2);
            localparam int SER_K = IS_SER ? i - gpio_port_pkg::PIN_SERIAL_LO : 0;
            localparam int USB_K = IS_USB ? i - gpio_port_pkg::PIN_DPLUS : 0;
            logic [7:0] cfg;
            logic float_mode;
            logic gpio_out;
            logic gpio_oe;

            // Per-pin configuration word
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                    cfg_reg[i] <= gpio_port_pkg::CFG_RESET;
                else if (wr_fire && wr_lane_reg
                    && wr_idx_reg == 6'(gpio_port_pkg::IDX_CFG_BASE + 6'(i)))
                    cfg_reg[i] <= wr_data_reg;
            end
            assign cfg = cfg_reg[i];

            // Outside USB mode D+ can only pull low, whatever the float bit says
            assign float_mode = cfg[gpio_port_pkg::CFG_FLOAT_HIGH] || IS_DP; // see R22
            // Float mode drives only zeros; else both levels
            assign gpio_out = float_mode ? 1'b0 : data_reg[i]; // see R9 see R10
            assign gpio_oe = cfg[gpio_port_pkg::CFG_OUT_EN]
                && !(float_mode && data_reg[i]); // see R12 see R9

            // Shared functions own the pad first
            always_comb
            begin
                out_next[i] = gpio_out; // see R1
                oe_next[i] = gpio_oe;
                if (IS_GONE)
                begin
                    out_next[i] = 1'b0; // see R20
                    oe_next[i] = 1'b0;
                end
                else if (IS_USB && func_reg[gpio_port_pkg::FN_USB_EN])
                begin
                    if (func_reg[gpio_port_pkg::FN_USB_FORCE])
                    begin
                        out_next[i] = data_reg[i]; // see R17
                        oe_next[i] = 1'b1;
                    end
                    else
                    begin
                        out_next[i] = usb_line_out[USB_K]; // see R16
                        oe_next[i] = usb_line_oe[USB_K];
                    end
                end
                else if (IS_SER && func_reg[gpio_port_pkg::FN_SERIAL_USE])
                begin
                    out_next[i] = serial_out[SER_K]; // see R18
                    oe_next[i] = serial_oe[SER_K]; // see R13
                end
                else if (IS_REG && func_reg[gpio_port_pkg::FN_REG_CLAIM])
                begin
                    out_next[i] = 1'b0; // see R13
                    oe_next[i] = 1'b0;
                end
            end

            // Static pad controls; USB mode masks pull-up on D+ D-
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    pull_up_en[i] <= 1'b0;
                    ttl_sel[i] <= 1'b0;
                    strong_sink[i] <= 1'b0;
                    high_from_regulator[i] <= 1'b0;
                end
                else
                begin
                    pull_up_en[i] <= cfg[gpio_port_pkg::CFG_PULL_UP] && !IS_GONE
                        && !(IS_USB && func_reg[gpio_port_pkg::FN_USB_EN]); // see R11
                    ttl_sel[i] <= cfg[gpio_port_pkg::CFG_TTL]; // see R7
                    strong_sink[i] <= cfg[gpio_port_pkg::CFG_STRONG_SINK] && IS_SINK; // see R8
                    high_from_regulator[i] <= cfg[gpio_port_pkg::CFG_LOW_V_DRIVE]
                        && IS_SER; // see R14
                end
            end

            // Unbuilt port 2 pins never fire
            assign int_en[i] = cfg[gpio_port_pkg::CFG_INT_EN] && !IS_GONE; // see R3
            assign int_low[i] = cfg[gpio_port_pkg::CFG_ACT_LOW]; // see R5
        end
    endgenerate

    // Registered pad drive keeps glitches off the pins
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pin_out <= '0;
            pin_oe <= '0;
        end
        else
        begin
            pin_out <= out_next;
            pin_oe <= oe_next;
        end
    end

    // Driven pads read back, so firmware can self-interrupt
    edge_irq #(
        .WIDTH(N)
    ) u_pin_irq (
        .clk_sys(clk_sys),
        .reset(reset),
        .level(pin_sync_lvl), // see R6
        .enable(int_en),
        .act_low(int_low),
        .active(pin_active),
        .pulse(pin_pulse)
    );

    // Shared port 2 interrupt rearms once all pins are inactive
    assign group_level[0] = |pin_active[23:16]; // see R4
    edge_irq #(
        .WIDTH(1)
    ) u_group_irq (
        .clk_sys(clk_sys),
        .reset(reset),
        .level(group_level),
        .enable(1'b1),
        .act_low(1'b0),
        .active(group_active),
        .pulse(group_pulse)
    );
    assign port2_irq = group_pulse[0];

    // Pins 3 and 4 feed dedicated vectors when routed there
    always_comb
    begin
        gpio_irq = pin_pulse;
        gpio_irq[23:16] = 8'h00;
        ext_irq_one = 1'b0;
        ext_irq_two = 1'b0;
        if (func_reg[gpio_port_pkg::FN_EXT_IRQ_USE])
        begin
            ext_irq_one = pin_pulse[gpio_port_pkg::PIN_EXT_ONE]; // see R19
            ext_irq_two = pin_pulse[gpio_port_pkg::PIN_EXT_TWO]; // see R19
            gpio_irq[gpio_port_pkg::PIN_EXT_ONE] = 1'b0;
            gpio_irq[gpio_port_pkg::PIN_EXT_TWO] = 1'b0;
        end
    end
endmodule // gpio_port_block
`default_nettype wire

// ===== tb/gpio_port_block_monitor.sv
// Purpose: Port checker for gpio_port_block
// Assumes: One clock, synchronous active-high reset
// Notes: Sees only top-level ports
`timescale 1ns/1ns
`default_nettype none
module gpio_port_block_monitor (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic s_axi_arvalid, // Read request
    input wire logic s_axi_arready, // Read accept
    input wire logic s_axi_rvalid, // Read answer
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [23:0] gpio_irq, // Pin pulses
    input wire logic [23:0] pin_oe, // Drive enables
    input wire logic [23:0] pin_out, // Drive levels
    input wire logic usb_mode, // USB owns 9:8
    input wire logic [23:0] strong_sink, // Sink select
    input wire logic [23:0] high_from_regulator // Rail select
);
    // One clock domain, reset cycles skipped
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read upper bits set");
    a_port2_quiet: assert property (gpio_irq[23:16] == 8'h00)
        else $error("port 2 pin pulse");
    // A held pulse would count as a second edge
    a_irq_pulse: assert property (|gpio_irq |=> (gpio_irq & $past(gpio_irq)) == 24'h000000)
        else $error("pulse too long");
    a_dplus_drain: assert property (!usb_mode && !$past(usb_mode) |-> !(pin_oe[8] && pin_out[8]))
        else $error("drain pin driven high");
    a_sink_pins: assert property ((strong_sink & 24'hff07ff) == 24'h000000)
        else $error("sink on wrong pin");
    a_lowv_pins: assert property ((high_from_regulator & 24'hff87ff) == 24'h000000)
        else $error("rail on wrong pin");
endmodule // gpio_port_block_monitor
bind gpio_port_block gpio_port_block_monitor u_gpio_port_block_monitor (.*);
`default_nettype wire

// ===== tb/gpio_pad_model.sv
// Purpose: Board side of the GPIO pads
// Assumes: Board drives only where the block does not
// Notes: Floating pads toggle so no stale level reads back
`timescale 1ns/1ns
`default_nettype none
module gpio_pad_model (
    input wire logic clk_sys, // Clock
    input wire logic [23:0] pin_out, // Block drive
    input wire logic [23:0] pin_oe, // Block enables
    input wire logic [23:0] pull_up_en, // Pull-ups
    input wire logic [23:0] ext_val, // Board level
    input wire logic [23:0] ext_en, // Board drive on
    output logic [23:0] pin_in // Pad levels
);
    logic [23:0] stir = 24'h5a5a5a;
    // Undriven, unpulled pads wander
    always_ff @(posedge clk_sys)
        stir <= ~stir;
    // Block driver first, then board, then pull-up
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pull_up_en | stir));
endmodule // gpio_pad_model
`default_nettype wire

// ===== tb/gpio_port_block_tb_top.sv
// Purpose: Directed bench for gpio_port_block
// Assumes: bready and rready held high
// Notes: Pads resolved by gpio_pad_model
`timescale 1ns/1ns
`default_nettype none
module gpio_port_block_tb_top;
    logic clk_sys = 1'b0, reset = 1'b1, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, d;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, serial_out = 4'h0, serial_oe = 4'h0;
    logic [1:0] usb_line_out = 2'h0, usb_line_oe = 2'h0, usb_line_in, s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, usb_mode;
    logic port2_irq, ext_irq_one, ext_irq_two, regulator_pin_claim, regulator_on, serial_data_in_pin;
    logic [23:0] pin_in, pin_out, pin_oe, pull_up_en, ttl_sel, strong_sink, high_from_regulator;
    logic [23:0] gpio_irq, ext_val = 24'hff005a, ext_en = 24'hffffff;
    int errors = 0, n_tests = 0;
    gpio_port_block u_gpio_port_block (.*);
    gpio_pad_model u_gpio_pad_model (.*);
    // 125 MHz clock
    initial
        forever #4 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // One AXI transfer, w selects write; waits bounded
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        do
        begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!(w ? s_axi_bvalid : s_axi_rvalid) && n < 40);
        d = s_axi_rdata[7:0];
        r = w ? s_axi_bresp : s_axi_rresp;
        chk(n < 40, 1'b1);
        if (n == 40) print_verdict();
        @(posedge clk_sys);
    endtask
    // Pulse seen in 8 cycles; 24 port 2, 25 ext one
    task automatic pulse(input int i, input logic e);
        logic s = 1'b0;
        repeat (8)
        begin
            @(posedge clk_sys);
            s |= (i == 24) ? port2_irq : (i == 25) ? ext_irq_one : gpio_irq[i];
        end
        chk(s, e);
    endtask
    task automatic t_pads();
        bus(1'b0, 8'h84, 8'h00);
        chk(d, gpio_port_pkg::CFG_RESET);
        bus(1'b0, 8'h40, 8'h00);
        chk(r, gpio_port_pkg::RESP_SLVERR);
        bus(1'b1, 8'h00, 8'hff);
        bus(1'b0, 8'h00, 8'h00);
        chk(d, 8'h5a);
        bus(1'b0, 8'h08, 8'h00);
        chk(d, 8'h03);
        bus(1'b1, 8'h84, 8'h01);
        ext_en[1] <= 1'b0;
        chk({pin_oe[1], pin_out[1]}, 2'b11);
        bus(1'b1, 8'h84, 8'h05);
        chk(pin_oe[1] & pin_out[1], 1'b0);
        bus(1'b1, 8'h00, 8'h00);
        chk({pin_oe[1], pin_out[1]}, 2'b10);
        $display("pads done");
    endtask
    task automatic t_irq();
        bus(1'b1, 8'h9c, 8'h40);
        ext_val[7] <= 1'b1;
        pulse(7, 1'b1);
        ext_val[7] <= 1'b0;
        pulse(7, 1'b0);
        // Off before changing polarity, so no stray pulse
        bus(1'b1, 8'h9c, 8'h00);
        ext_val[7] <= 1'b1;
        bus(1'b1, 8'h9c, 8'h60);
        ext_val[7] <= 1'b0;
        pulse(7, 1'b1);
        bus(1'b1, 8'h9c, 8'h00);
        ext_val[7] <= 1'b1;
        pulse(7, 1'b0);
        bus(1'b1, 8'h94, 8'h41);
        ext_en[5] <= 1'b0;
        bus(1'b1, 8'h00, 8'h20);
        pulse(5, 1'b1);
        ext_val[17:16] <= 2'b00;
        bus(1'b1, 8'hc0, 8'h40);
        bus(1'b1, 8'hc4, 8'h40);
        ext_val[16] <= 1'b1;
        pulse(24, 1'b1);
        ext_val[17] <= 1'b1;
        pulse(24, 1'b0);
        ext_val[3] <= 1'b0;
        bus(1'b1, 8'h20, 8'h10);
        bus(1'b1, 8'h8c, 8'h40);
        ext_val[3] <= 1'b1;
        pulse(25, 1'b1);
        $display("irq done");
    endtask
    task automatic t_func();
        bus(1'b1, 8'hac, 8'h9b);
        chk({pull_up_en[11], ttl_sel[11], strong_sink[11], high_from_regulator[11]}, 4'hf);
        usb_line_oe <= 2'b11;
        usb_line_out <= 2'b01;
        // Regulator turned on by its own bit
        bus(1'b1, 8'h20, 8'h25);
        chk({usb_mode, regulator_pin_claim, regulator_on, pin_oe[10]}, 4'he);
        chk({pin_oe[9:8], pin_out[9:8]}, 4'hd);
        bus(1'b1, 8'h20, 8'h27);
        bus(1'b1, 8'h04, 8'h02);
        chk({pin_oe[9:8], pin_out[9:8]}, 4'he);
        $display("func done");
    endtask
    // Reset, scenarios, verdict
    initial
    begin
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (3) @(posedge clk_sys);
        t_pads();
        t_irq();
        t_func();
        print_verdict();
    end
endmodule // gpio_port_block_tb_top
`default_nettype wire
